// [design/timer_control_two_logic.sv]
// Overview of operation
// - Idle: ch0 main output follows its level
// - Idle: ch0 complementary follows its level
// - Channels 1-2 idle bits behave alike; channel 3 has main only, no dead-time wait
// - Idle bits writable only when lock open
// - Main idle waits dead-time with complement
// - Trigger input: ch0 pin or XOR
// - Mode 000: pulse on counter reset
// - Mode 001: pulse on counter start
// - Mode 010: pulse on update event
// - Mode 011: pulse on ch0 event
// - Modes 100-111: compare reference edges
// - DMA request on channel event or update
// - Commutation load by request or trigger
// - Shadowed enables apply at commutation only
// - Channels without complement ignore shadowing
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module timer_control_two_logic
    import timer_ctl_two_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_output_enable,
    input wire logic [1:0] lock_level,
    input wire logic [7:0] dead_time,
    input wire logic [2:0] ch_pin,
    input wire logic counter_reset_event,
    input wire logic counter_start_event,
    input wire logic update_event,
    input wire logic [3:0] ch_event,
    input wire logic [3:0] compare_reference,
    input wire logic [3:0] ch_active_main,
    input wire logic [2:0] ch_active_comp,
    input wire logic slave_trigger_in,
    input wire logic software_commutation_request,
    output logic ch0_trigger_input,
    output logic master_trigger_out,
    output logic [3:0] dma_req,
    output logic [3:0] main_output,
    output logic [2:0] comp_output,
    output logic [3:0] channel_main_enable,
    output logic [2:0] channel_comp_enable,
    output logic [11:0] channel_compare_control
);
    state_t cur;
    state_t next_s;
    logic wr;
    logic rd;
    logic [31:0] wmask;
    logic commute;
    logic [3:0] ref_rise;
    logic trig_pulse;
    logic [31:0] ctl_wr;
    logic [31:0] idle_keep;

    assign wr = psel && penable && pwrite && !cur.pready;
    assign rd = psel && penable && !pwrite && !cur.pready;
    assign ref_rise = compare_reference & ~cur.ref_prev;

    // Idle bits keep their value unless the lock level is open.
    assign idle_keep = (lock_level == lock_open) ? 32'h00000000 : 32'h00007F00;

    // A commutation happens on request, or on a trigger edge when enabled.
    assign commute = software_commutation_request ||
        (cur.ctl_two[upd_ctl_pos] && slave_trigger_in && !cur.slave_trig_prev);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = pstrb[gi] ? 8'hFF : 8'h00;
        end
    endgenerate
    assign ctl_wr = (cur.ctl_two & ~(wmask & ctl_two_write_mask & ~idle_keep)) |
        (pwdata & wmask & ctl_two_write_mask & ~idle_keep);

    always_comb begin
        next_s = cur;
        next_s.pready = psel && penable && !cur.pready;
        next_s.pslverr = 1'b0;
        next_s.prdata = 32'h00000000;
        if (psel && penable && !cur.pready) begin
            unique case (paddr)
                ctl_two_addr: begin
                    if (wr) begin
                        next_s.ctl_two = ctl_wr;
                    end
                    if (rd) begin
                        next_s.prdata = cur.ctl_two;
                    end
                end
                chan_ctl_addr: begin
                    if (wr) begin
                        next_s.chan_pre = pwdata[18:0];
                    end
                    if (rd) begin
                        next_s.prdata = {13'h0000, cur.chan_act};
                    end
                end
                status_addr: begin
                    if (rd) begin
                        next_s.prdata = {22'h000000, cur.master_trigger_out, cur.trig_in, cur.dt_cnt};
                    end
                    next_s.pslverr = wr;
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        // Channel 3 has no complement, so its controls always pass straight through.
        if (!cur.ctl_two[shadow_en_pos] || commute) begin
            next_s.chan_act = next_s.chan_pre;
        end else begin
            next_s.chan_act.main_en[3] = next_s.chan_pre.main_en[3];
            next_s.chan_act.cmp_ctl[11:9] = next_s.chan_pre.cmp_ctl[11:9];
        end
        next_s.trig_in = cur.ctl_two[trig_sel_pos] ? ^ch_pin : ch_pin[0];
        next_s.slave_trig_prev = slave_trigger_in;
        next_s.ref_prev = compare_reference;
        unique case (cur.ctl_two[mm_lsb +: 3])
            mm_reset: trig_pulse = counter_reset_event;
            mm_start: trig_pulse = counter_start_event;
            mm_update: trig_pulse = update_event;
            mm_ch0_event: trig_pulse = ch_event[0];
            default: trig_pulse = ref_rise[cur.ctl_two[mm_lsb +: 2]];
        endcase
        next_s.master_trigger_out = trig_pulse && !cur.master_trigger_out;
        next_s.dma_req = cur.ctl_two[dma_sel_pos] ? {4{update_event}} : ch_event;
        // Dead-time counts from entering idle; main outputs 0-2 hold until it ends, main output 3 takes its idle level at once.
        next_s.idle_prev = !primary_output_enable;
        if (primary_output_enable) begin
            next_s.dt_cnt = dead_time_reset;
        end else if (!cur.idle_prev) begin
            next_s.dt_cnt = dead_time;
        end else if (cur.dt_cnt != dead_time_reset) begin
            next_s.dt_cnt = cur.dt_cnt - 8'h01;
        end
        if (primary_output_enable) begin
            next_s.main_out = ch_active_main;
            next_s.comp_out = ch_active_comp;
        end else begin
            next_s.comp_out = {cur.ctl_two[idle_lsb+5], cur.ctl_two[idle_lsb+3], cur.ctl_two[idle_lsb+1]};
            next_s.main_out[3] = cur.ctl_two[idle_lsb+6];
            if (cur.idle_prev && cur.dt_cnt == dead_time_reset) begin
                next_s.main_out[2:0] = {cur.ctl_two[idle_lsb+4], cur.ctl_two[idle_lsb+2],
                    cur.ctl_two[idle_lsb]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_s;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign ch0_trigger_input = cur.trig_in;
    assign master_trigger_out = cur.master_trigger_out;
    assign dma_req = cur.dma_req;
    assign main_output = cur.main_out;
    assign comp_output = cur.comp_out;
    assign channel_main_enable = cur.chan_act.main_en;
    assign channel_comp_enable = cur.chan_act.comp_en;
    assign channel_compare_control = cur.chan_act.cmp_ctl;

    chk_trig_sel: assert property (@(posedge pclk) disable iff (!presetn)
        !cur.ctl_two[trig_sel_pos] |=> ch0_trigger_input == $past(ch_pin[0]))
        else $error("trigger input select wrong");
    chk_trig_xor: assert property (@(posedge pclk) disable iff (!presetn)
        cur.ctl_two[trig_sel_pos] |=> ch0_trigger_input == ^$past(ch_pin))
        else $error("trigger input xor wrong");
    chk_trig_single: assert property (@(posedge pclk) disable iff (!presetn)
        master_trigger_out |=> !master_trigger_out)
        else $error("master trigger longer than one cycle");
    chk_mode_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[6:4] == 3'h0 && counter_reset_event && !master_trigger_out) |=> master_trigger_out)
        else $error("reset event gave no trigger");
    chk_mode_update: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[6:4] == 3'h2 && !update_event) |=> !master_trigger_out)
        else $error("trigger without update");
    chk_dma_update: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[dma_sel_pos] && update_event) |=> dma_req == 4'hF)
        else $error("dma not on update");
    chk_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (lock_level != 2'h0) |=> cur.ctl_two[14:8] == $past(cur.ctl_two[14:8]))
        else $error("idle bits changed while locked");
    chk_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[0] && !commute) |=> channel_comp_enable == $past(cur.chan_act.comp_en))
        else $error("shadowed enable moved early");
    chk_idle_comp: assert property (@(posedge pclk) disable iff (!presetn)
        !primary_output_enable |=> comp_output[0] == $past(cur.ctl_two[9]))
        else $error("complement idle level wrong");

    // Main outputs 0-2 wait at idle entry and for every cycle that the dead-time count still runs.
    sequence seq_dead_wait;
        !primary_output_enable && (!cur.idle_prev || cur.dt_cnt != dead_time_reset);
    endsequence
    sequence seq_main_hold;
        main_output[2:0] == $past(main_output[2:0]);
    endsequence
    sequence seq_idle_enter;
        !primary_output_enable && !cur.idle_prev;
    endsequence
    sequence seq_dead_over;
        !primary_output_enable && cur.idle_prev && cur.dt_cnt == dead_time_reset;
    endsequence

    chk_dead_load: assert property (@(posedge pclk) disable iff (!presetn)
        seq_idle_enter |=> cur.dt_cnt == $past(dead_time))
        else $error("dead-time count not loaded at idle entry");
    chk_dead_hold: assert property (@(posedge pclk) disable iff (!presetn)
        seq_dead_wait |=> seq_main_hold)
        else $error("main output moved before dead-time ended");
    chk_idle_main: assert property (@(posedge pclk) disable iff (!presetn)
        seq_dead_over |=> main_output[2:0] ==
            {$past(cur.ctl_two[12]), $past(cur.ctl_two[10]), $past(cur.ctl_two[8])})
        else $error("main idle level wrong");
    chk_idle_ch3: assert property (@(posedge pclk) disable iff (!presetn)
        !primary_output_enable |=> main_output[3] == $past(cur.ctl_two[14]))
        else $error("channel 3 idle level wrong");
    chk_idle_comp_all: assert property (@(posedge pclk) disable iff (!presetn)
        !primary_output_enable |=> comp_output ==
            {$past(cur.ctl_two[13]), $past(cur.ctl_two[11]), $past(cur.ctl_two[9])})
        else $error("complement idle levels wrong");
    chk_active_main: assert property (@(posedge pclk) disable iff (!presetn)
        primary_output_enable |=> main_output == $past(ch_active_main))
        else $error("main output not following active level");
    chk_active_comp: assert property (@(posedge pclk) disable iff (!presetn)
        primary_output_enable |=> comp_output == $past(ch_active_comp))
        else $error("complement output not following active level");

    // Each trigger mode must fire on its own cause and stay quiet otherwise.
    chk_mode_reset_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[mm_lsb +: 3] == mm_reset && !counter_reset_event) |=> !master_trigger_out)
        else $error("trigger without reset event");
    chk_mode_start: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[mm_lsb +: 3] == mm_start && counter_start_event && !master_trigger_out) |=> master_trigger_out)
        else $error("start event gave no trigger");
    chk_start_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[mm_lsb +: 3] == mm_start && !counter_start_event) |=> !master_trigger_out)
        else $error("trigger without start event");
    chk_mode_update_hit: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[mm_lsb +: 3] == mm_update && update_event && !master_trigger_out) |=> master_trigger_out)
        else $error("update event gave no trigger");
    chk_mode_ch0: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[mm_lsb +: 3] == mm_ch0_event && ch_event[0] && !master_trigger_out) |=> master_trigger_out)
        else $error("channel 0 event gave no trigger");
    chk_ch0_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[mm_lsb +: 3] == mm_ch0_event && !ch_event[0]) |=> !master_trigger_out)
        else $error("trigger without channel 0 event");
    chk_ref_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[6] && ref_rise[cur.ctl_two[5:4]] && !master_trigger_out) |=> master_trigger_out)
        else $error("compare reference edge gave no trigger");
    chk_ref_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[6] && !ref_rise[cur.ctl_two[5:4]]) |=> !master_trigger_out)
        else $error("trigger without compare reference edge");

    // Requests follow their selected source one cycle later.
    chk_dma_channel: assert property (@(posedge pclk) disable iff (!presetn)
        !cur.ctl_two[dma_sel_pos] |=> dma_req == $past(ch_event))
        else $error("dma not on channel event");
    chk_dma_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[dma_sel_pos] && !update_event) |=> dma_req == 4'h0)
        else $error("dma without update");

    // Register access: an open lock lets the idle bits take the written byte.
    chk_lock_open_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && !pready && paddr == ctl_two_addr && lock_level == lock_open && pstrb[1])
            |=> cur.ctl_two[14:8] == $past(pwdata[14:8]))
        else $error("idle bits not written while unlocked");
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cur.ctl_two[31:15] == 17'h00000 && !cur.ctl_two[1])
        else $error("reserved control bits set");
    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_status_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && !pready && paddr == status_addr) |=> pslverr)
        else $error("status write not refused");

    // Commutation: with shadowing off or on a commutation, the active copy matches the written one.
    chk_direct_enable: assert property (@(posedge pclk) disable iff (!presetn)
        !cur.ctl_two[shadow_en_pos] |=> cur.chan_act == cur.chan_pre)
        else $error("unshadowed enables not applied");
    chk_commute_load: assert property (@(posedge pclk) disable iff (!presetn)
        commute |=> cur.chan_act == cur.chan_pre)
        else $error("commutation did not load enables");
    chk_trig_edge_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.ctl_two[shadow_en_pos] && !cur.ctl_two[upd_ctl_pos] && !software_commutation_request)
            |=> channel_comp_enable == $past(channel_comp_enable))
        else $error("trigger edge commuted while not allowed");
    chk_ch3_direct: assert property (@(posedge pclk) disable iff (!presetn)
        channel_main_enable[3] == cur.chan_pre.main_en[3] &&
            channel_compare_control[11:9] == cur.chan_pre.cmp_ctl[11:9])
        else $error("channel 3 controls shadowed");
endmodule
`default_nettype wire

// [design/timer_ctl_two_pkg.sv]
package timer_ctl_two_pkg;
    localparam logic [11:0] ctl_two_addr = 12'h004;
    localparam logic [11:0] chan_ctl_addr = 12'h020;
    localparam logic [11:0] status_addr = 12'h024;
    localparam logic [31:0] ctl_two_reset = 32'h00000000;
    localparam logic [31:0] ctl_two_write_mask = 32'h00007FFD;
    localparam int shadow_en_pos = 0;
    localparam int upd_ctl_pos = 2;
    localparam int dma_sel_pos = 3;
    localparam int mm_lsb = 4;
    localparam int trig_sel_pos = 7;
    localparam int idle_lsb = 8;
    localparam int num_ch = 4;
    localparam logic [2:0] mm_reset = 3'h0;
    localparam logic [2:0] mm_start = 3'h1;
    localparam logic [2:0] mm_update = 3'h2;
    localparam logic [2:0] mm_ch0_event = 3'h3;
    localparam logic [1:0] lock_open = 2'h0;
    localparam logic [7:0] dead_time_reset = 8'h00;
    typedef struct packed {
        logic [3:0] main_en;
        logic [2:0] comp_en;
        logic [11:0] cmp_ctl;
    } chan_ctl_t;
    typedef struct packed {
        logic [31:0] ctl_two;
        chan_ctl_t chan_pre;
        chan_ctl_t chan_act;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic master_trigger_out;
        logic [3:0] dma_req;
        logic trig_in;
        logic trig_prev;
        logic slave_trig_prev;
        logic [3:0] main_out;
        logic [2:0] comp_out;
        logic [7:0] dt_cnt;
        logic idle_prev;
        logic [3:0] ref_prev;
    } state_t;
endpackage

// [sim/far_side_model.sv]
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic master_trigger_out,
    input wire logic [3:0] dma_req,
    output logic [7:0] trig_seen,
    output logic [7:0] dma_seen
);
    // A slave timer acts on every cycle the trigger is high, so a stretched pulse counts twice here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_seen <= 8'h00;
            dma_seen <= 8'h00;
        end else begin
            trig_seen <= trig_seen + {7'h00, master_trigger_out};
            dma_seen <= dma_seen + {7'h00, |dma_req};
        end
    end
endmodule
`default_nettype wire

// [sim/timer_control_two_logic_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module timer_control_two_logic_bench
    import timer_ctl_two_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, ch0_trigger_input, master_trigger_out;
    logic primary_output_enable = 1'b1, slave_trigger_in = 1'b0, software_commutation_request = 1'b0;
    logic [1:0] lock_level = 2'h0;
    logic [7:0] dead_time = 8'h03, cause = 8'h00, trig_seen, dma_seen;
    logic [2:0] ch_pin = 3'h0, chh = 3'h0, ch_active_comp = 3'h2, comp_output, channel_comp_enable;
    logic [3:0] ch_active_main = 4'h5, dma_req, main_output, channel_main_enable;
    logic [11:0] channel_compare_control;
    int err_total = 0, samples_checked = 0, cycles = 0;
    always #5 pclk = ~pclk;
    timer_control_two_logic u_timer_control_two_logic (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .primary_output_enable, .lock_level, .dead_time, .ch_pin,
        .counter_reset_event(cause[0]), .counter_start_event(cause[1]), .update_event(cause[2]),
        .ch_event({chh, cause[3]}), .compare_reference(cause[7:4]), .ch_active_main, .ch_active_comp,
        .slave_trigger_in, .software_commutation_request, .ch0_trigger_input, .master_trigger_out, .dma_req,
        .main_output, .comp_output, .channel_main_enable, .channel_comp_enable, .channel_compare_control);
    far_side_model u_far_side_model (.pclk, .presetn, .master_trigger_out, .dma_req, .trig_seen, .dma_seen);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rv, exp);
    endtask
    // Leaves the caller at the edge that shows the registered reaction to the pulse.
    task automatic pulse(input logic [7:0] c, input logic [2:0] h);
        @(posedge pclk);
        cause <= c;
        chh <= h;
        @(posedge pclk);
        cause <= 8'h00;
        chh <= 3'h0;
        @(posedge pclk);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ctl_two_addr, 32'h00000000);
        apb(1'b1, ctl_two_addr, 32'hFFFFFFFF);
        rd(ctl_two_addr, 32'h00007FFD);
        lock_level <= 2'h1;
        apb(1'b1, ctl_two_addr, 32'h0);
        rd(ctl_two_addr, 32'h00007F00);
        lock_level <= 2'h0;
        pstrb <= 4'h2;
        apb(1'b1, ctl_two_addr, 32'h000000FF);
        pstrb <= 4'hF;
        rd(ctl_two_addr, 32'h00000000);
        apb(1'b1, ctl_two_addr, 32'h00007F00);
        apb(1'b0, 12'hFFC, 32'h0);
        check({31'h0, last_err}, 32'h1);
        $display("register test done");
        check({main_output, comp_output}, 32'h2A);
        primary_output_enable <= 1'b0;
        repeat (2) @(posedge pclk);
        check({main_output[2:0], comp_output}, 32'h2F);
        repeat (8) @(posedge pclk);
        check({main_output, comp_output}, 32'h7F);
        apb(1'b1, ctl_two_addr, 32'h0);
        repeat (6) @(posedge pclk);
        check({main_output, comp_output}, 32'h00);
        primary_output_enable <= 1'b1;
        ch_pin <= 3'h3;
        apb(1'b1, ctl_two_addr, 32'h80);
        repeat (2) @(posedge pclk);
        check({31'h0, ch0_trigger_input}, 32'h0);
        apb(1'b1, ctl_two_addr, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, ch0_trigger_input}, 32'h1);
        rd(status_addr, 32'h00000100);
        apb(1'b1, status_addr, 32'h0);
        check({31'h0, last_err}, 32'h1);
        $display("idle and trigger input test done");
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, ctl_two_addr, 32'(m) << mm_lsb);
            pulse(8'h01 << m, 3'h0);
            check({31'h0, master_trigger_out}, 32'h1);
            @(posedge pclk);
            check({31'h0, master_trigger_out}, 32'h0);
        end
        check(trig_seen, 32'h8);
        apb(1'b1, ctl_two_addr, 32'h0);
        pulse(8'h08, 3'h7);
        check(dma_req, 32'hF);
        apb(1'b1, ctl_two_addr, 32'h8);
        pulse(8'h04, 3'h0);
        check(dma_req, 32'hF);
        $display("trigger and dma test done");
        apb(1'b1, ctl_two_addr, 32'h0);
        apb(1'b1, chan_ctl_addr, 32'h7FFFF);
        repeat (2) @(posedge pclk);
        check({channel_main_enable, channel_comp_enable, channel_compare_control}, 32'h7FFFF);
        apb(1'b1, ctl_two_addr, 32'h1);
        apb(1'b1, chan_ctl_addr, 32'h0);
        slave_trigger_in <= 1'b1;
        repeat (3) @(posedge pclk);
        check({channel_main_enable, channel_comp_enable, channel_compare_control}, 32'h3F1FF);
        slave_trigger_in <= 1'b0;
        software_commutation_request <= 1'b1;
        @(posedge pclk);
        software_commutation_request <= 1'b0;
        repeat (2) @(posedge pclk);
        check({channel_main_enable, channel_comp_enable, channel_compare_control}, 32'h0);
        apb(1'b1, chan_ctl_addr, 32'h7FFFF);
        apb(1'b1, ctl_two_addr, 32'h5);
        slave_trigger_in <= 1'b1;
        repeat (3) @(posedge pclk);
        check({channel_main_enable, channel_comp_enable, channel_compare_control}, 32'h7FFFF);
        check(dma_seen, 32'h3);
        $display("commutation test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
